// file: logic/egf_pkg.sv
package egf_pkg;
	// Clock period of the filter clock
	localparam int CLK_NS = 25;
	localparam int CODE_W = 8;
	localparam int CNT_W = 21;
	localparam int NUM_CODES = 19;
	localparam int LAST_CODE = 18;
	localparam int FIRST_LONG_CODE = 11;
	// Filter delay per code, in ns
	localparam int FILT_NS [NUM_CODES] = '{20, 100, 200, 500, 1000, 2000, 5000, 10000, 20000, 50000,
		100000, 200000, 500000, 1000000, 2000000, 5000000, 10000000, 20000000, 50000000};

	localparam logic [7:0] A_RISE_OFS = 8'h00;
	localparam logic [7:0] A_FALL_OFS = 8'h04;
	localparam logic [7:0] B_RISE_OFS = 8'h08;
	localparam logic [7:0] B_FALL_OFS = 8'h0c;
	localparam logic [7:0] Z_RISE_OFS = 8'h10;
	localparam logic [7:0] Z_FALL_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;
	localparam int STAT_FILT_LSB = 0;
	localparam int STAT_RAW_LSB = 3;
	localparam logic [7:0] CODE_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// A least time rounds up, never below one cycle
	function automatic int filt_cyc(input int code);
		int cyc;
		cyc = (FILT_NS[code] + CLK_NS - 1) / CLK_NS;
		return (cyc < 1) ? 1 : cyc;
	endfunction
endpackage

// file: logic/egf_if.sv
`timescale 1ns/10ps
interface egf_filt_if;
	logic                        raw;
	logic                        filt;
	logic [egf_pkg::CNT_W-1:0]   rise_need;
	logic [egf_pkg::CNT_W-1:0]   fall_need;
	modport ctl (output raw, output rise_need, output fall_need, input filt);
	modport flt (input raw, input rise_need, input fall_need, output filt);
endinterface

interface egf_reg_if;
	logic         wr_en;
	logic [7:0]   wr_addr;
	logic [7:0]   wr_data;
	logic         wr_strb;
	logic         wr_err;
	logic [7:0]   rd_addr;
	logic [31:0]  rd_data;
	logic         rd_err;
	modport slv (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr,
		input wr_err, input rd_data, input rd_err);
	modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr,
		output wr_err, output rd_data, output rd_err);
endinterface

// file: logic/egf_filter.sv
`timescale 1ns/10ps
module egf_filter (
	input  wire logic    clock_in,
	input  wire logic    rstn_in,
	egf_filt_if.flt      fi
);
	logic [egf_pkg::CNT_W-1:0] cnt_ff;
	logic [egf_pkg::CNT_W-1:0] need;
	logic [egf_pkg::CNT_W-1:0] hi_run_ff;
	logic [egf_pkg::CNT_W-1:0] lo_run_ff;
	logic                      filt_ff;

	assign fi.filt = filt_ff;
	assign need = filt_ff ? fi.fall_need : fi.rise_need;

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			filt_ff <= 1'b0;
			cnt_ff <= '0;
		end else if (fi.raw == filt_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff >= need - egf_pkg::CNT_W'(1)) begin
			filt_ff <= fi.raw;
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + egf_pkg::CNT_W'(1);
		end
	end

	// Run lengths of the raw level, read only by the checks below
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hi_run_ff <= '0;
			lo_run_ff <= '0;
		end else begin
			hi_run_ff <= !fi.raw ? '0 : (&hi_run_ff ? hi_run_ff : hi_run_ff + egf_pkg::CNT_W'(1));
			lo_run_ff <= fi.raw ? '0 : (&lo_run_ff ? lo_run_ff : lo_run_ff + egf_pkg::CNT_W'(1));
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	a_rise_held: assert property ($rose(filt_ff) |-> hi_run_ff >= $past(fi.rise_need))
		else $error("filtered level rose before the rising delay");
	a_fall_held: assert property ($fell(filt_ff) |-> lo_run_ff >= $past(fi.fall_need))
		else $error("filtered level fell before the falling delay");
	a_restart_count: assert property ((fi.raw == filt_ff) |=> cnt_ff == '0)
		else $error("delay count not restarted");
	a_no_flip: assert property ($changed(filt_ff) |-> $past(fi.raw) != $past(filt_ff))
		else $error("filtered level changed without a differing input");
endmodule // egf_filter

// file: logic/egf_axil_slave.sv
`timescale 1ns/10ps
module egf_axil_slave (
	input  wire logic          clock_in,
	input  wire logic          rstn_in,
	input  wire logic [7:0]    awaddr_in,
	input  wire logic          awvalid_in,
	output logic               awready_out,
	input  wire logic [31:0]   wdata_in,
	input  wire logic [3:0]    wstrb_in,
	input  wire logic          wvalid_in,
	output logic               wready_out,
	output logic [1:0]         bresp_out,
	output logic               bvalid_out,
	input  wire logic          bready_in,
	input  wire logic [7:0]    araddr_in,
	input  wire logic          arvalid_in,
	output logic               arready_out,
	output logic [31:0]        rdata_out,
	output logic [1:0]         rresp_out,
	output logic               rvalid_out,
	input  wire logic          rready_in,
	egf_reg_if.slv             rb
);
	logic [7:0] waddr_ff;
	logic [7:0] wdat_ff;
	logic       wstb_ff;
	logic       aw_have_ff;
	logic       w_have_ff;
	logic [7:0] raddr_ff;
	logic       rd_pend_ff;

	assign rb.wr_en = aw_have_ff && w_have_ff && !bvalid_out;
	assign rb.wr_addr = waddr_ff;
	assign rb.wr_data = wdat_ff;
	assign rb.wr_strb = wstb_ff;
	assign rb.rd_addr = raddr_ff;

	// Address and data are taken in either order; ready drops until the response is taken
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			awready_out <= 1'b0;
			wready_out <= 1'b0;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			waddr_ff <= '0;
			wdat_ff <= '0;
			wstb_ff <= 1'b0;
			bvalid_out <= 1'b0;
			bresp_out <= egf_pkg::RESP_OKAY;
		end else begin
			if (!aw_have_ff && !bvalid_out)
				awready_out <= !(awvalid_in && awready_out);
			if (!w_have_ff && !bvalid_out)
				wready_out <= !(wvalid_in && wready_out);
			if (awvalid_in && awready_out) begin
				aw_have_ff <= 1'b1;
				waddr_ff <= awaddr_in;
			end
			if (wvalid_in && wready_out) begin
				w_have_ff <= 1'b1;
				wdat_ff <= wdata_in[7:0];
				wstb_ff <= wstrb_in[0];
			end
			if (rb.wr_en) begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				bvalid_out <= 1'b1;
				bresp_out <= rb.wr_err ? egf_pkg::RESP_SLVERR : egf_pkg::RESP_OKAY;
			end else if (bvalid_out && bready_in) begin
				bvalid_out <= 1'b0;
				awready_out <= 1'b1;
				wready_out <= 1'b1;
			end
		end
	end

	// Read data is looked up one cycle after the address is taken
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			arready_out <= 1'b0;
			raddr_ff <= '0;
			rd_pend_ff <= 1'b0;
			rvalid_out <= 1'b0;
			rdata_out <= '0;
			rresp_out <= egf_pkg::RESP_OKAY;
		end else begin
			if (arvalid_in && arready_out) begin
				arready_out <= 1'b0;
				raddr_ff <= araddr_in;
				rd_pend_ff <= 1'b1;
			end else if (rd_pend_ff) begin
				rd_pend_ff <= 1'b0;
				rvalid_out <= 1'b1;
				rdata_out <= rb.rd_data;
				rresp_out <= rb.rd_err ? egf_pkg::RESP_SLVERR : egf_pkg::RESP_OKAY;
			end else if (rvalid_out && rready_in) begin
				rvalid_out <= 1'b0;
				arready_out <= 1'b1;
			end else if (!rvalid_out) begin
				arready_out <= 1'b1;
			end
		end
	end
endmodule // egf_axil_slave

// file: logic/egf_top.sv
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module egf_top #(
	parameter int CNT_200US = egf_pkg::filt_cyc(11),
	parameter int CNT_500US = egf_pkg::filt_cyc(12),
	parameter int CNT_1MS   = egf_pkg::filt_cyc(13),
	parameter int CNT_2MS   = egf_pkg::filt_cyc(14),
	parameter int CNT_5MS   = egf_pkg::filt_cyc(15),
	parameter int CNT_10MS  = egf_pkg::filt_cyc(16),
	parameter int CNT_20MS  = egf_pkg::filt_cyc(17),
	parameter int CNT_50MS  = egf_pkg::filt_cyc(18)
) (
	input  wire logic          clock_in,
	input  wire logic          rstn_in,
	input  wire logic          a_raw_in,
	input  wire logic          b_raw_in,
	input  wire logic          z_raw_in,
	output logic               a_filt_out,
	output logic               b_filt_out,
	output logic               z_filt_out,
	input  wire logic [7:0]    s_axi_awaddr_in,
	input  wire logic          s_axi_awvalid_in,
	output logic               s_axi_awready_out,
	input  wire logic [31:0]   s_axi_wdata_in,
	input  wire logic [3:0]    s_axi_wstrb_in,
	input  wire logic          s_axi_wvalid_in,
	output logic               s_axi_wready_out,
	output logic [1:0]         s_axi_bresp_out,
	output logic               s_axi_bvalid_out,
	input  wire logic          s_axi_bready_in,
	input  wire logic [7:0]    s_axi_araddr_in,
	input  wire logic          s_axi_arvalid_in,
	output logic               s_axi_arready_out,
	output logic [31:0]        s_axi_rdata_out,
	output logic [1:0]         s_axi_rresp_out,
	output logic               s_axi_rvalid_out,
	input  wire logic          s_axi_rready_in
);
	localparam int CW = egf_pkg::CNT_W;

	logic [7:0] a_rise_filter_code_ff;
	logic [7:0] a_fall_filter_code_ff;
	logic [7:0] b_rise_filter_code_ff;
	logic [7:0] b_fall_filter_code_ff;
	logic [7:0] z_rise_filter_code_ff;
	logic [7:0] z_fall_filter_code_ff;

	egf_reg_if  rb ();
	egf_filt_if a_if ();
	egf_filt_if b_if ();
	egf_filt_if z_if ();

	function automatic logic [CW-1:0] code_cnt(input logic [7:0] code);
		int c;
		int n;
		c = (code > 8'(egf_pkg::LAST_CODE)) ? egf_pkg::LAST_CODE : int'(code);
		case (c)
			11: n = CNT_200US;
			12: n = CNT_500US;
			13: n = CNT_1MS;
			14: n = CNT_2MS;
			15: n = CNT_5MS;
			16: n = CNT_10MS;
			17: n = CNT_20MS;
			18: n = CNT_50MS;
			default: n = egf_pkg::filt_cyc(c);
		endcase
		// A shortened parameter must still give at least one cycle
		return (n < 1) ? CW'(1) : CW'(n);
	endfunction

	assign a_if.raw = a_raw_in;
	assign b_if.raw = b_raw_in;
	assign z_if.raw = z_raw_in;
	assign a_if.rise_need = code_cnt(a_rise_filter_code_ff);
	assign a_if.fall_need = code_cnt(a_fall_filter_code_ff);
	assign b_if.rise_need = code_cnt(b_rise_filter_code_ff);
	assign b_if.fall_need = code_cnt(b_fall_filter_code_ff);
	assign z_if.rise_need = code_cnt(z_rise_filter_code_ff);
	assign z_if.fall_need = code_cnt(z_fall_filter_code_ff);

	// Filtered levels are flip-flops inside each filter
	assign a_filt_out = a_if.filt;
	assign b_filt_out = b_if.filt;
	assign z_filt_out = z_if.filt;

	egf_filter u_filt_a (
		.clock_in (clock_in),
		.rstn_in  (rstn_in),
		.fi       (a_if)
	);
	egf_filter u_filt_b (
		.clock_in (clock_in),
		.rstn_in  (rstn_in),
		.fi       (b_if)
	);
	egf_filter u_filt_z (
		.clock_in (clock_in),
		.rstn_in  (rstn_in),
		.fi       (z_if)
	);

	egf_axil_slave u_bus (
		.clock_in    (clock_in),
		.rstn_in     (rstn_in),
		.awaddr_in   (s_axi_awaddr_in),
		.awvalid_in  (s_axi_awvalid_in),
		.awready_out (s_axi_awready_out),
		.wdata_in    (s_axi_wdata_in),
		.wstrb_in    (s_axi_wstrb_in),
		.wvalid_in   (s_axi_wvalid_in),
		.wready_out  (s_axi_wready_out),
		.bresp_out   (s_axi_bresp_out),
		.bvalid_out  (s_axi_bvalid_out),
		.bready_in   (s_axi_bready_in),
		.araddr_in   (s_axi_araddr_in),
		.arvalid_in  (s_axi_arvalid_in),
		.arready_out (s_axi_arready_out),
		.rdata_out   (s_axi_rdata_out),
		.rresp_out   (s_axi_rresp_out),
		.rvalid_out  (s_axi_rvalid_out),
		.rready_in   (s_axi_rready_in),
		.rb          (rb)
	);

	// Writes to status or unmapped words are refused with an error response
	always_comb begin
		case (rb.wr_addr)
			egf_pkg::A_RISE_OFS, egf_pkg::A_FALL_OFS, egf_pkg::B_RISE_OFS,
			egf_pkg::B_FALL_OFS, egf_pkg::Z_RISE_OFS, egf_pkg::Z_FALL_OFS: rb.wr_err = 1'b0;
			default: rb.wr_err = 1'b1;
		endcase
	end

	// Codes live in byte lane 0 only; other lanes are ignored
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			a_rise_filter_code_ff <= egf_pkg::CODE_RST;
			a_fall_filter_code_ff <= egf_pkg::CODE_RST;
			b_rise_filter_code_ff <= egf_pkg::CODE_RST;
			b_fall_filter_code_ff <= egf_pkg::CODE_RST;
			z_rise_filter_code_ff <= egf_pkg::CODE_RST;
			z_fall_filter_code_ff <= egf_pkg::CODE_RST;
		end else if (rb.wr_en && rb.wr_strb) begin
			case (rb.wr_addr)
				egf_pkg::A_RISE_OFS: a_rise_filter_code_ff <= rb.wr_data;
				egf_pkg::A_FALL_OFS: a_fall_filter_code_ff <= rb.wr_data;
				egf_pkg::B_RISE_OFS: b_rise_filter_code_ff <= rb.wr_data;
				egf_pkg::B_FALL_OFS: b_fall_filter_code_ff <= rb.wr_data;
				egf_pkg::Z_RISE_OFS: z_rise_filter_code_ff <= rb.wr_data;
				egf_pkg::Z_FALL_OFS: z_fall_filter_code_ff <= rb.wr_data;
				default: ;
			endcase
		end
	end

	always_comb begin
		rb.rd_data = '0;
		rb.rd_err = 1'b0;
		case (rb.rd_addr)
			egf_pkg::A_RISE_OFS: rb.rd_data[7:0] = a_rise_filter_code_ff;
			egf_pkg::A_FALL_OFS: rb.rd_data[7:0] = a_fall_filter_code_ff;
			egf_pkg::B_RISE_OFS: rb.rd_data[7:0] = b_rise_filter_code_ff;
			egf_pkg::B_FALL_OFS: rb.rd_data[7:0] = b_fall_filter_code_ff;
			egf_pkg::Z_RISE_OFS: rb.rd_data[7:0] = z_rise_filter_code_ff;
			egf_pkg::Z_FALL_OFS: rb.rd_data[7:0] = z_fall_filter_code_ff;
			egf_pkg::STATUS_OFS: begin
				rb.rd_data[egf_pkg::STAT_FILT_LSB +: 3] = {z_if.filt, b_if.filt, a_if.filt};
				rb.rd_data[egf_pkg::STAT_RAW_LSB +: 3] = {z_raw_in, b_raw_in, a_raw_in};
			end
			default: rb.rd_err = 1'b1;
		endcase
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	sequence s_z_fall_write;
		rb.wr_en && rb.wr_strb && (rb.wr_addr == egf_pkg::Z_FALL_OFS);
	endsequence

	a_code_zero: assert property ((a_rise_filter_code_ff == 8'h00) |-> a_if.rise_need == CW'(1))
		else $error("code 0 does not give one cycle");
	a_code_mid: assert property ((b_fall_filter_code_ff == 8'h04) |-> b_if.fall_need == CW'(40))
		else $error("code 4 does not give 1 us");
	a_code_max: assert property ((z_rise_filter_code_ff == 8'h12) |-> z_if.rise_need == CW'(CNT_50MS))
		else $error("code 18 does not give 50 ms");
	a_z_fall_load: assert property (s_z_fall_write |=> z_fall_filter_code_ff == $past(rb.wr_data))
		else $error("z falling code not loaded");
	a_z_fall_steer: assert property (s_z_fall_write ##1 1'b1 |-> z_if.fall_need == code_cnt(z_fall_filter_code_ff))
		else $error("z falling delay not steered by its code");
	a_write_resp: assert property (rb.wr_en |=> s_axi_bvalid_out ##0 (s_axi_bresp_out == ($past(rb.wr_err, 1) ?
		egf_pkg::RESP_SLVERR : egf_pkg::RESP_OKAY)))
		else $error("write response missing or wrong");
	a_read_answer: assert property ((s_axi_arvalid_in && s_axi_arready_out) |-> ##2 s_axi_rvalid_out)
		else $error("read answer not two cycles after address");

	// Bus handshake steps that software relies on
	sequence s_aw_take;
		s_axi_awvalid_in && s_axi_awready_out;
	endsequence

	sequence s_w_take;
		s_axi_wvalid_in && s_axi_wready_out;
	endsequence

	sequence s_b_wait;
		s_axi_bvalid_out && !s_axi_bready_in;
	endsequence

	sequence s_r_wait;
		s_axi_rvalid_out && !s_axi_rready_in;
	endsequence

	sequence s_refused_write;
		rb.wr_en && (rb.wr_err || !rb.wr_strb);
	endsequence

	a_aw_drop: assert property (s_aw_take |=> !s_axi_awready_out)
		else $error("address ready stayed high after take");
	a_w_drop: assert property (s_w_take |=> !s_axi_wready_out)
		else $error("data ready stayed high after take");
	a_b_hold: assert property (s_b_wait |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped before it was taken");
	a_r_hold: assert property (s_r_wait |=> s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
		else $error("read answer dropped before it was taken");

	a_refused_keep: assert property (s_refused_write |=> $stable(a_rise_filter_code_ff)
		&& $stable(a_fall_filter_code_ff) && $stable(b_rise_filter_code_ff) && $stable(b_fall_filter_code_ff)
		&& $stable(z_rise_filter_code_ff) && $stable(z_fall_filter_code_ff))
		else $error("refused write changed a code");

	// codes beyond the table act as the last
	a_code_clamp: assert property ((b_rise_filter_code_ff > 8'(egf_pkg::LAST_CODE))
		|-> b_if.rise_need == CW'(CNT_50MS))
		else $error("code above the table not clamped");

	// matching input holds the reported level
	a_a_quiet: assert property ((a_raw_in == a_filt_out) |=> $stable(a_filt_out))
		else $error("A level moved while the input matched it");
	a_b_quiet: assert property ((b_raw_in == b_filt_out) |=> $stable(b_filt_out))
		else $error("B level moved while the input matched it");
	a_z_quiet: assert property ((z_raw_in == z_filt_out) |=> $stable(z_filt_out))
		else $error("Z level moved while the input matched it");

	// code zero follows in one cycle
	a_a_fast_rise: assert property ((a_rise_filter_code_ff == 8'h00 && !a_filt_out && a_raw_in)
		|=> a_filt_out)
		else $error("A did not follow at once with code zero");
endmodule // egf_top

// file: testbench/egf_enc_src.sv
`timescale 1ns/10ps
module egf_enc_src (
	input  wire logic    clock_in,
	output logic [2:0]   raw_out
);
	initial raw_out = 3'h0;
	// Levels change just after an edge so every edge sees a settled line
	task automatic set_lvl(input int ch, input logic lvl);
		@(posedge clock_in);
		raw_out[ch] <= lvl;
	endtask
endmodule // egf_enc_src

// file: testbench/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
	localparam int LONG_N [8] = '{20, 30, 40, 50, 60, 70, 80, 100};
	logic          clock_in;
	logic          rstn_in;
	logic [2:0]    raw;
	logic [2:0]    filt;
	logic [7:0]    awaddr;
	logic [7:0]    araddr;
	logic [31:0]   wdata;
	logic [31:0]   rdata;
	logic [3:0]    wstrb;
	logic [1:0]    bresp;
	logic [1:0]    rresp;
	logic          awvalid;
	logic          awready;
	logic          wvalid;
	logic          wready;
	logic          bvalid;
	logic          bready;
	logic          arvalid;
	logic          arready;
	logic          rvalid;
	logic          rready;
	int            fail_count;
	int            n_checks;

	egf_enc_src enc (.clock_in(clock_in), .raw_out(raw));

	egf_top #(
		.CNT_200US(LONG_N[0]), .CNT_500US(LONG_N[1]), .CNT_1MS(LONG_N[2]), .CNT_2MS(LONG_N[3]),
		.CNT_5MS(LONG_N[4]), .CNT_10MS(LONG_N[5]), .CNT_20MS(LONG_N[6]), .CNT_50MS(LONG_N[7])
	) dut (
		.clock_in(clock_in), .rstn_in(rstn_in), .a_raw_in(raw[0]), .b_raw_in(raw[1]), .z_raw_in(raw[2]),
		.a_filt_out(filt[0]), .b_filt_out(filt[1]), .z_filt_out(filt[2]),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready)
	);

	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic [1:0] got;
		logic       done;
		int         t;
		got = 2'h3;
		done = 1'b0;
		t = 0;
		@(posedge clock_in);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && t < 200) begin
			@(posedge clock_in);
			t++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				got = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		`CHK("bresp", er, got)
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] got;
		logic [1:0]  gr;
		logic        done;
		int          t;
		got = 32'hxxxxxxxx;
		gr = 2'h3;
		done = 1'b0;
		t = 0;
		@(posedge clock_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && t < 200) begin
			@(posedge clock_in);
			t++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				got = rdata;
				gr = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		`CHK("rdata", ed, got)
		`CHK("rresp", er, gr)
	endtask

	// Codes above the table behave as the last code
	function automatic int exp_n(input int c);
		int k;
		k = (c > egf_pkg::LAST_CODE) ? egf_pkg::LAST_CODE : c;
		if (k >= egf_pkg::FIRST_LONG_CODE)
			return LONG_N[k - egf_pkg::FIRST_LONG_CODE];
		return (egf_pkg::FILT_NS[k] + egf_pkg::CLK_NS - 1) / egf_pkg::CLK_NS;
	endfunction

	// A bounce one cycle short of the delay must not leak through
	task automatic flip(input int ch, input logic lvl, input int n, input logic bounce);
		if (bounce && n > 1) begin
			enc.set_lvl(ch, lvl);
			repeat (n - 2) @(posedge clock_in);
			enc.set_lvl(ch, !lvl);
			#1;
			`CHK("filt_bounce", !lvl, filt[ch])
		end
		enc.set_lvl(ch, lvl);
		repeat (n - 1) @(posedge clock_in);
		#1;
		`CHK("filt_early", !lvl, filt[ch])
		@(posedge clock_in);
		#1;
		`CHK("filt_late", lvl, filt[ch])
	endtask

	initial begin
		repeat (60000) @(posedge clock_in);
		fail_count++;
		report_and_stop();
	end

	initial begin
		int code;
		int fc;
		int ch;
		fail_count = 0;
		n_checks = 0;
		rstn_in = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (12) @(posedge clock_in);
		rstn_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		for (int i = 0; i < 7; i++)
			rd(8'(i * 4), 32'h0, egf_pkg::RESP_OKAY);
		wr(egf_pkg::A_RISE_OFS, 32'h000001ab, 4'hf, egf_pkg::RESP_OKAY);
		rd(egf_pkg::A_RISE_OFS, 32'h000000ab, egf_pkg::RESP_OKAY);
		// Byte lane zero off leaves the code untouched
		wr(egf_pkg::A_RISE_OFS, 32'h00000005, 4'h0, egf_pkg::RESP_OKAY);
		rd(egf_pkg::A_RISE_OFS, 32'h000000ab, egf_pkg::RESP_OKAY);
		wr(egf_pkg::STATUS_OFS, 32'h00000001, 4'hf, egf_pkg::RESP_SLVERR);
		wr(8'h20, 32'h00000001, 4'hf, egf_pkg::RESP_SLVERR);
		rd(8'h20, 32'h0, egf_pkg::RESP_SLVERR);
		$display("test registers done");
		// Rise and fall codes differ so a swapped selection shows
		for (int k = 0; k < 20; k++) begin
			code = (k == 19) ? 25 : k;
			fc = (k + 7) % 19;
			ch = k % 3;
			wr(8'(ch * 8), 32'(code), 4'hf, egf_pkg::RESP_OKAY);
			wr(8'(ch * 8 + 4), 32'(fc), 4'hf, egf_pkg::RESP_OKAY);
			rd(8'(ch * 8), 32'(code), egf_pkg::RESP_OKAY);
			flip(ch, 1'b1, exp_n(code), 1'b1);
			rd(egf_pkg::STATUS_OFS, 32'h9 << ch, egf_pkg::RESP_OKAY);
			flip(ch, 1'b0, exp_n(fc), 1'b1);
		end
		$display("test filter codes done");
		report_and_stop();
	end
endmodule // testbench
